/* File: cpu_arith_logic_unit.sv */
// Arithmetic, logic and multiply datapath with its working-register bank and status flags
`timescale 1ns/1ps

module cpu_arith_logic_unit #(
  parameter int DATA_W = alu_pkg::DATA_W,
  parameter int NUM_REGS = alu_pkg::NUM_REGS
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire alu_pkg::cmd_t i_cmd,
  input wire alu_pkg::bus_req_t i_bus,
  output logic [7:0] o_rdata,
  output logic [7:0] o_status,
  output logic o_busy,
  output logic o_done
);

  // The datapath is written for the documented byte width and bank size only
  if (DATA_W != alu_pkg::DATA_W || NUM_REGS != alu_pkg::NUM_REGS) begin : g_check
    $error("cpu_arith_logic_unit supports only an 8-bit datapath with 32 registers");
  end

  logic [7:0] regs [alu_pkg::NUM_REGS];
  alu_pkg::phase_t phase;
  logic [15:0] pend_res;
  logic [7:0] pend_status;
  logic [4:0] pend_base;

  // Command acceptance; commands offered during the second phase are ignored
  wire accept = i_ce && i_cmd.valid && (phase == alu_pkg::phase_idle);
  wire is_word = (i_cmd.op == alu_pkg::add_immediate_word)
              || (i_cmd.op == alu_pkg::subtract_immediate_word);
  wire is_mult = (i_cmd.op >= alu_pkg::multiply_unsigned);
  wire is_double = is_word || is_mult;
  wire accept_single = accept && !is_double;
  wire accept_double = accept && is_double;
  wire finish_double = i_ce && (phase == alu_pkg::phase_second);

  // Operand selection; word ops use an even-aligned pair, low bit of rd ignored
  wire uses_imm = (i_cmd.op == alu_pkg::subtract_immediate)
               || (i_cmd.op == alu_pkg::subtract_immediate_with_carry)
               || (i_cmd.op == alu_pkg::and_immediate) || (i_cmd.op == alu_pkg::or_immediate)
               || (i_cmd.op == alu_pkg::set_mask_bits) || (i_cmd.op == alu_pkg::clear_mask_bits);
  wire [4:0] pair_lo = {i_cmd.rd[4:1], 1'b0};
  wire [4:0] pair_hi = {i_cmd.rd[4:1], 1'b1};
  wire [7:0] opa = is_word ? regs[pair_lo] : regs[i_cmd.rd];
  wire [7:0] opb = uses_imm ? i_cmd.imm : regs[i_cmd.rr];
  wire [7:0] word_hi = regs[pair_hi];
  wire carry_in = o_status[alu_pkg::C_BIT];
  wire use_carry = (i_cmd.op == alu_pkg::add_with_carry)
                || (i_cmd.op == alu_pkg::subtract_with_carry)
                || (i_cmd.op == alu_pkg::subtract_immediate_with_carry);
  wire cin = use_carry && carry_in;

  // Shared byte adder and subtractor; bit 8 is carry or borrow
  wire [8:0] sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
  wire [8:0] dif9 = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
  wire add_h = (opa[3] & opb[3]) | (opb[3] & ~sum9[3]) | (~sum9[3] & opa[3]);
  wire add_v = (opa[7] & opb[7] & ~sum9[7]) | (~opa[7] & ~opb[7] & sum9[7]);
  wire sub_h = (~opa[3] & opb[3]) | (opb[3] & dif9[3]) | (dif9[3] & ~opa[3]);
  wire sub_v = (opa[7] & ~opb[7] & ~dif9[7]) | (~opa[7] & opb[7] & dif9[7]);

  // Word arithmetic on the pair with a six-bit constant
  wire [15:0] pair_val = {word_hi, opa};
  wire [15:0] imm16 = {10'h000, i_cmd.imm[alu_pkg::WORD_IMM_W-1:0]};
  wire [15:0] word_sum = pair_val + imm16;
  wire [15:0] word_dif = pair_val - imm16;

  // Multiplier: operands widened per signedness, product kept to 16 bits
  wire sign_a = (i_cmd.op == alu_pkg::multiply_signed)
             || (i_cmd.op == alu_pkg::multiply_signed_unsigned)
             || (i_cmd.op == alu_pkg::fractional_multiply_signed)
             || (i_cmd.op == alu_pkg::fractional_multiply_mixed);
  wire sign_b = (i_cmd.op == alu_pkg::multiply_signed)
             || (i_cmd.op == alu_pkg::fractional_multiply_signed);
  wire signed [8:0] mult_a = {sign_a & opa[7], opa};
  wire signed [8:0] mult_b = {sign_b & opb[7], opb};
  wire signed [17:0] mult_full = mult_a * mult_b;
  wire [15:0] product = mult_full[15:0];
  wire is_frac = (i_cmd.op >= alu_pkg::fractional_multiply_unsigned);
  wire [15:0] product_out = is_frac ? {product[14:0], 1'b0} : product;

  logic [15:0] res;
  logic [7:0] fmask;
  logic cand_c;
  logic cand_v;
  logic cand_h;
  logic wr_byte;

  // Per-operation result and candidate flags; N, Z and S are derived below
  always_comb
  begin
    res = {8'h00, opa};
    fmask = alu_pkg::MASK_ZNV;
    cand_c = 1'b0;
    cand_v = 1'b0;
    cand_h = 1'b0;
    wr_byte = 1'b1;
    unique case (i_cmd.op)
      alu_pkg::add_registers, alu_pkg::add_with_carry:
      begin
        res = {8'h00, sum9[7:0]};
        fmask = alu_pkg::MASK_ZCNVH;
        cand_c = sum9[8];
        cand_v = add_v;
        cand_h = add_h;
      end
      alu_pkg::subtract_registers, alu_pkg::subtract_immediate,
      alu_pkg::subtract_with_carry, alu_pkg::subtract_immediate_with_carry:
      begin
        res = {8'h00, dif9[7:0]};
        fmask = alu_pkg::MASK_ZCNVH;
        cand_c = dif9[8];
        cand_v = sub_v;
        cand_h = sub_h;
      end
      alu_pkg::add_immediate_word:
      begin
        res = word_sum;
        fmask = alu_pkg::MASK_ZCNVS;
        wr_byte = 1'b0;
        cand_c = ~word_sum[15] & word_hi[7];
        cand_v = ~word_hi[7] & word_sum[15];
      end
      alu_pkg::subtract_immediate_word:
      begin
        res = word_dif;
        fmask = alu_pkg::MASK_ZCNVS;
        wr_byte = 1'b0;
        cand_c = word_dif[15] & ~word_hi[7];
        cand_v = word_hi[7] & ~word_dif[15];
      end
      alu_pkg::and_registers, alu_pkg::and_immediate:
        res = {8'h00, opa & opb};
      alu_pkg::or_registers, alu_pkg::or_immediate, alu_pkg::set_mask_bits:
        res = {8'h00, opa | opb};
      alu_pkg::exclusive_or_registers:
        res = {8'h00, opa ^ opb};
      alu_pkg::clear_mask_bits:
        res = {8'h00, opa & (alu_pkg::ALL_ONES - opb)};
      alu_pkg::test_zero_minus:
        res = {8'h00, opa & opa};
      alu_pkg::clear_register:
        res = {8'h00, opa ^ opa};
      alu_pkg::set_register_all_ones:
      begin
        res = {8'h00, alu_pkg::ALL_ONES};
        fmask = alu_pkg::MASK_NONE;
      end
      alu_pkg::ones_complement:
      begin
        res = {8'h00, alu_pkg::ALL_ONES - opa};
        fmask = alu_pkg::MASK_ZCNV;
        cand_c = 1'b1;
      end
      alu_pkg::twos_complement:
      begin
        res = {8'h00, alu_pkg::ALL_ZERO - opa};
        fmask = alu_pkg::MASK_ZCNVH;
        cand_c = (opa != alu_pkg::ALL_ZERO);
        cand_v = (opa == alu_pkg::MIN_NEG);
        cand_h = res[3] | opa[3];
      end
      alu_pkg::increment_register:
      begin
        res = {8'h00, 8'(opa + 8'h01)};
        cand_v = (opa == alu_pkg::MAX_POS);
      end
      alu_pkg::decrement_register:
      begin
        res = {8'h00, 8'(opa - 8'h01)};
        cand_v = (opa == alu_pkg::MIN_NEG);
      end
      default:
      begin
        // Multiplies: carry is the unshifted product's top bit
        res = product_out;
        fmask = alu_pkg::MASK_ZC;
        wr_byte = 1'b0;
        cand_c = product[15];
      end
    endcase
  end

  // Derived flags; wide results test all 16 bits for zero
  wire res_zero = is_double ? (res == 16'h0000) : (res[7:0] == alu_pkg::ALL_ZERO);
  wire res_neg = is_word ? res[15] : res[7];
  logic [7:0] flag_vals;
  always_comb
  begin
    flag_vals = 8'h00;
    flag_vals[alu_pkg::C_BIT] = cand_c;
    flag_vals[alu_pkg::Z_BIT] = res_zero;
    flag_vals[alu_pkg::N_BIT] = res_neg;
    flag_vals[alu_pkg::V_BIT] = cand_v;
    flag_vals[alu_pkg::S_BIT] = res_neg ^ cand_v;
    flag_vals[alu_pkg::H_BIT] = cand_h;
  end
  wire [7:0] next_status = (o_status & ~fmask) | (flag_vals & fmask);

  // Phase control; two-clock ops hold their result one cycle, then commit the pair
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n) begin
      phase <= alu_pkg::phase_idle;
      pend_res <= 16'h0000;
      pend_status <= alu_pkg::STATUS_RESET;
      pend_base <= 5'h00;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= accept_single || finish_double;
      if (accept_double) begin
        phase <= alu_pkg::phase_second;
        pend_res <= res;
        pend_status <= next_status;
        pend_base <= is_word ? pair_lo : alu_pkg::PRODUCT_LO_IDX;
        o_busy <= 1'b1;
      end else if (finish_double) begin
        phase <= alu_pkg::phase_idle;
        o_busy <= 1'b0;
      end
    end
  end

  // Status register; datapath updates win over a port write in the same cycle
  wire bus_wr_status = i_bus.wr && (i_bus.addr == alu_pkg::STATUS_ADDR);
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n) begin
      o_status <= alu_pkg::STATUS_RESET;
    end else if (i_ce) begin
      if (finish_double) begin
        o_status <= pend_status;
      end else if (accept_single) begin
        o_status <= next_status;
      end else if (bus_wr_status) begin
        o_status <= i_bus.wdata;
      end
    end
  end

  // Working registers, one flip-flop byte per entry
  for (genvar i = 0; i < alu_pkg::NUM_REGS; i++) begin : g_reg
    wire hit_byte = accept_single && wr_byte && (i_cmd.rd == 5'(i));
    wire hit_lo = finish_double && (pend_base == 5'(i));
    wire hit_hi = finish_double && ((pend_base + 5'h01) == 5'(i));
    wire hit_bus = i_bus.wr && !i_bus.addr[5] && (i_bus.addr[4:0] == 5'(i));
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
      if (!i_rst_n) begin
        regs[i] <= alu_pkg::REG_RESET;
      end else if (i_ce) begin
        if (hit_lo) begin
          regs[i] <= pend_res[7:0];
        end else if (hit_hi) begin
          regs[i] <= pend_res[15:8];
        end else if (hit_byte) begin
          regs[i] <= res[7:0];
        end else if (hit_bus) begin
          regs[i] <= i_bus.wdata;
        end
      end
    end
  end

  // Port read data: valid only in the cycle after the read strobe, zero elsewhere
  wire [7:0] read_mux = !i_bus.addr[5] ? regs[i_bus.addr[4:0]]
                      : (i_bus.addr == alu_pkg::STATUS_ADDR) ? o_status : 8'h00;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      o_rdata <= i_bus.rd ? read_mux : 8'h00;
    end
  end

  // Checking aid: operands of the op that is in flight
  alu_pkg::op_t last_op;
  logic [4:0] last_rd;
  logic [7:0] last_a;
  logic [7:0] last_b;
  logic [7:0] last_hi;
  logic last_c;
  logic [7:0] last_status;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n) begin
      last_op <= alu_pkg::add_registers;
      last_rd <= 5'h00;
      last_a <= 8'h00;
      last_b <= 8'h00;
      last_hi <= 8'h00;
      last_c <= 1'b0;
      last_status <= 8'h00;
    end else if (accept) begin
      last_op <= i_cmd.op;
      last_rd <= is_word ? pair_lo : i_cmd.rd;
      last_a <= opa;
      last_b <= is_word ? i_cmd.imm : opb;
      last_hi <= word_hi;
      last_c <= carry_in;
      last_status <= o_status;
    end
  end
  wire done_op = o_done;
  wire [15:0] pair_now = {regs[last_rd + 5'h01], regs[last_rd]};
  wire [15:0] prod_now = {regs[1], regs[0]};

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // A two-clock op that is not frozen in its second clock
  sequence s_double_start;
    accept_double ##1 i_ce;
  endsequence
  sequence s_double_end;
    (o_busy && !o_done) ##1 (o_done && !o_busy);
  endsequence

  property p_add;
    done_op && (last_op == alu_pkg::add_with_carry)
      |-> {o_status[alu_pkg::C_BIT], regs[last_rd]} == 9'(last_a) + 9'(last_b) + 9'(last_c);
  endproperty
  a_add: assert property (p_add) else $error("add with carry result wrong");
  property p_word_add;
    done_op && (last_op == alu_pkg::add_immediate_word)
      |-> pair_now == 16'({last_hi, last_a} + {10'h000, last_b[5:0]});
  endproperty
  a_word_add: assert property (p_word_add) else $error("word add result wrong");
  property p_sub;
    done_op && (last_op == alu_pkg::subtract_registers)
      |-> {o_status[alu_pkg::C_BIT], regs[last_rd]} == 9'(9'(last_a) - 9'(last_b));
  endproperty
  a_sub: assert property (p_sub) else $error("subtract result wrong");
  property p_borrow;
    done_op && (last_op == alu_pkg::subtract_with_carry)
      |-> regs[last_rd] == 8'(last_a - last_b - 8'(last_c));
  endproperty
  a_borrow: assert property (p_borrow) else $error("subtract with carry wrong");
  property p_borrow_k;
    done_op && (last_op == alu_pkg::subtract_immediate_with_carry)
      |-> o_status[alu_pkg::Z_BIT] == (regs[last_rd] == 8'h00);
  endproperty
  a_borrow_k: assert property (p_borrow_k) else $error("borrow-immediate Z wrong");
  property p_word_timing;
    s_double_start |-> s_double_end;
  endproperty
  a_word_timing: assert property (p_word_timing) else $error("two-clock op not done");
  property p_and;
    done_op && (last_op == alu_pkg::and_immediate)
      |-> regs[last_rd] == (last_a & last_b) && !o_status[alu_pkg::V_BIT];
  endproperty
  a_and: assert property (p_and) else $error("and result or overflow wrong");
  property p_xor;
    done_op && (last_op == alu_pkg::exclusive_or_registers)
      |-> o_status[alu_pkg::N_BIT] == (last_a[7] ^ last_b[7]);
  endproperty
  a_xor: assert property (p_xor) else $error("xor negative flag wrong");
  property p_set_bits;
    done_op && (last_op == alu_pkg::set_mask_bits) |-> regs[last_rd] == (last_a | last_b);
  endproperty
  a_set_bits: assert property (p_set_bits) else $error("set-bits result wrong");
  property p_clear_bits;
    done_op && (last_op == alu_pkg::clear_mask_bits) |-> regs[last_rd] == (last_a & ~last_b);
  endproperty
  a_clear_bits: assert property (p_clear_bits) else $error("clear-bits result wrong");
  property p_set_ones;
    done_op && (last_op == alu_pkg::set_register_all_ones)
      |-> regs[last_rd] == 8'hff && o_status == last_status;
  endproperty
  a_set_ones: assert property (p_set_ones) else $error("set-all-ones wrong");
  property p_signed_prod;
    done_op && (last_op == alu_pkg::multiply_signed)
      |-> prod_now == 16'($signed(last_a) * $signed(last_b));
  endproperty
  a_signed_prod: assert property (p_signed_prod) else $error("signed product wrong");
  property p_frac_prod;
    done_op && (last_op == alu_pkg::fractional_multiply_unsigned)
      |-> prod_now == 16'({8'h00, last_a} * {8'h00, last_b} * 16'h0002);
  endproperty
  a_frac_prod: assert property (p_frac_prod) else $error("fractional product wrong");
  property p_neg;
    done_op && (last_op == alu_pkg::twos_complement)
      |-> regs[last_rd] == 8'(8'h00 - last_a) && o_status[alu_pkg::C_BIT] == (last_a != 8'h00);
  endproperty
  a_neg: assert property (p_neg) else $error("two's complement wrong");

endmodule // cpu_arith_logic_unit

/* File: alu_pkg.sv */
// Constants, opcodes and carrier types shared by the arithmetic/logic datapath
package alu_pkg;
  // Datapath and register-bank shape
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 32;
  localparam int REG_IDX_W = 5;
  localparam int BUS_ADDR_W = 6;
  localparam int WORD_IMM_W = 6;

  // Register-port map: working registers at 0x00..0x1F, status at 0x20
  localparam logic [5:0] STATUS_ADDR = 6'h20;
  localparam logic [4:0] PRODUCT_LO_IDX = 5'h00;

  // Status register bit positions
  localparam int C_BIT = 0;
  localparam int Z_BIT = 1;
  localparam int N_BIT = 2;
  localparam int V_BIT = 3;
  localparam int S_BIT = 4;
  localparam int H_BIT = 5;

  // Flag update masks, one bit per status position
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_ZCNVH = 8'h2f;
  localparam logic [7:0] MASK_ZCNV = 8'h0f;
  localparam logic [7:0] MASK_ZCNVS = 8'h1f;
  localparam logic [7:0] MASK_ZNV = 8'h0e;
  localparam logic [7:0] MASK_ZC = 8'h03;

  // Reset values and fixed byte constants
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] ALL_ZERO = 8'h00;
  localparam logic [7:0] MIN_NEG = 8'h80;
  localparam logic [7:0] MAX_POS = 8'h7f;

  // Execution lengths in clocks
  localparam int CYCLES_SINGLE = 1;
  localparam int CYCLES_DOUBLE = 2;

  // Operations accepted from the decoder
  typedef enum logic [4:0] {
    add_registers = 5'h00, add_with_carry = 5'h01, add_immediate_word = 5'h02,
    subtract_registers = 5'h03, subtract_immediate = 5'h04, subtract_with_carry = 5'h05,
    subtract_immediate_with_carry = 5'h06, subtract_immediate_word = 5'h07,
    and_registers = 5'h08, and_immediate = 5'h09, or_registers = 5'h0a, or_immediate = 5'h0b,
    exclusive_or_registers = 5'h0c, ones_complement = 5'h0d, twos_complement = 5'h0e,
    set_mask_bits = 5'h0f, clear_mask_bits = 5'h10, increment_register = 5'h11,
    decrement_register = 5'h12, test_zero_minus = 5'h13, clear_register = 5'h14,
    set_register_all_ones = 5'h15, multiply_unsigned = 5'h16, multiply_signed = 5'h17,
    multiply_signed_unsigned = 5'h18, fractional_multiply_unsigned = 5'h19,
    fractional_multiply_signed = 5'h1a, fractional_multiply_mixed = 5'h1b
  } op_t;

  // Execution phase, one-hot
  typedef enum logic [1:0] {
    phase_idle = 2'b01,
    phase_second = 2'b10
  } phase_t;

  // Decoder command
  typedef struct packed {
    logic valid;
    op_t op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [7:0] imm;
  } cmd_t;

  // Register-port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } bus_req_t;
endpackage

/* File: alu_decoder_model.sv */
// Behavioural model of the instruction decoder that feeds the datapath
`timescale 1ns/1ps
module alu_decoder_model (
  input wire logic i_clk,
  output alu_pkg::cmd_t o_cmd
);
  // Idle command from time zero so the datapath never sees an unknown request
  initial o_cmd = '0;

  // Offers one command for exactly one clock; callers wait for completion before the next,
  // because a command offered while the datapath is busy is dropped without a trace
  task automatic issue(input alu_pkg::op_t op, input logic [4:0] rd,
    input logic [4:0] rr, input logic [7:0] imm);
    @(posedge i_clk);
    o_cmd <= '{valid: 1'b1, op: op, rd: rd, rr: rr, imm: imm};
    @(posedge i_clk);
    o_cmd <= '0;
  endtask
endmodule // alu_decoder_model

/* File: tb.sv */
// Self-checking testbench for the arithmetic, logic and multiply datapath
`timescale 1ns/1ps
module tb;
  logic i_clk;
  logic i_rst_n;
  logic i_ce;
  alu_pkg::cmd_t i_cmd;
  alu_pkg::bus_req_t i_bus;
  logic [7:0] o_rdata;
  logic [7:0] o_status;
  logic o_busy;
  logic o_done;
  logic [7:0] got;
  int fail_count;
  int checked;

  // Datapath under test and the decoder that feeds it
  cpu_arith_logic_unit cpu_arith_logic_unit_i (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_cmd(i_cmd),
    .i_bus(i_bus),
    .o_rdata(o_rdata),
    .o_status(o_status),
    .o_busy(o_busy),
    .o_done(o_done)
  );
  alu_decoder_model alu_decoder_model_i (
    .i_clk(i_clk),
    .o_cmd(i_cmd)
  );

  // 200 MHz core clock
  initial i_clk = 1'b0;
  always #2.5 i_clk = ~i_clk;

  // Compares one byte and counts the result
  task automatic check(input logic [7:0] gotv, input logic [7:0] exp, input string what);
    checked++;
    if (gotv !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, gotv, exp);
    end
  endtask

  // One-cycle write strobe on the register port
  task automatic bus_write(input logic [5:0] addr, input logic [7:0] data);
    @(posedge i_clk);
    i_bus <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge i_clk);
    i_bus <= '0;
  endtask

  // One-cycle read strobe; the data are only valid in the following cycle
  task automatic bus_read(input logic [5:0] addr, output logic [7:0] data);
    @(posedge i_clk);
    i_bus <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge i_clk);
    i_bus <= '0;
    #1;
    data = o_rdata;
  endtask

  // Loads operands and flags, runs one operation, then checks timing, flags and result.
  // Kind 0 is a byte op on r16/r17, 1 a word op on pair r25:r24, 2 a multiply of r16/r17 into r1:r0.
  task automatic op_case(input alu_pkg::op_t op, input logic [7:0] a, input logic [7:0] b,
    input logic [7:0] k, input logic [7:0] sin, input logic [15:0] res,
    input logic [7:0] sout, input int kind);
    logic [4:0] rd;
    logic [7:0] val;
    rd = (kind == 1) ? 5'h18 : 5'h10;
    bus_write({1'b0, rd}, a);
    bus_write({1'b0, rd + 5'h01}, b);
    bus_write(alu_pkg::STATUS_ADDR, sin);
    alu_decoder_model_i.issue(op, rd, rd + 5'h01, k);
    #1;
    if (kind == 0)
      check({7'h00, o_done}, 8'h01, "one-clock completion");
    else
    begin
      check({6'h00, o_busy, o_done}, 8'h02, "busy in first clock");
      @(posedge i_clk);
      #1;
      check({6'h00, o_busy, o_done}, 8'h01, "two-clock completion");
    end
    check(o_status, sout, "status flags");
    rd = (kind == 2) ? alu_pkg::PRODUCT_LO_IDX : rd;
    bus_read({1'b0, rd}, val);
    check(val, res[7:0], "result low byte");
    if (kind != 0)
    begin
      bus_read({1'b0, rd + 5'h01}, val);
      check(val, res[15:8], "result high byte");
    end
  endtask

  // Enable low freezes everything: a command offered then is lost, a multiply stalls in
  // its second clock; also checks that read data fall back to zero after their cycle
  task automatic ce_case();
    logic [7:0] val;
    bus_write(6'h10, 8'h03);
    bus_write(6'h11, 8'h05);
    bus_write(alu_pkg::STATUS_ADDR, 8'h00);
    @(posedge i_clk);
    i_ce <= 1'b0;
    alu_decoder_model_i.issue(alu_pkg::add_registers, 5'h10, 5'h11, 8'h00);
    i_ce <= 1'b1;
    #1;
    check({7'h00, o_done}, 8'h00, "command taken while disabled");
    bus_read(6'h10, val);
    check(val, 8'h03, "register changed while disabled");
    @(posedge i_clk);
    #1;
    check(o_rdata, 8'h00, "read data held past its cycle");
    alu_decoder_model_i.issue(alu_pkg::multiply_unsigned, 5'h10, 5'h11, 8'h00);
    i_ce <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    check({6'h00, o_busy, o_done}, 8'h02, "frozen second clock");
    @(posedge i_clk);
    i_ce <= 1'b1;
    @(posedge i_clk);
    #1;
    check({6'h00, o_busy, o_done}, 8'h01, "completion after enable returns");
    check(o_status, 8'h00, "status after frozen multiply");
    bus_read(6'h00, val);
    check(val, 8'h0f, "product low byte after freeze");
  endtask

  // Prints the counts and the verdict, then ends the run
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence: reset state, unmapped access, then every operation code
  initial
  begin
    fail_count = 0;
    checked = 0;
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    i_bus = '0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    bus_read(6'h05, got);
    check(got, alu_pkg::REG_RESET, "register after reset");
    check(o_status, alu_pkg::STATUS_RESET, "status after reset");
    bus_write(6'h21, 8'ha5);
    bus_read(6'h21, got);
    check(got, 8'h00, "unmapped read");
    op_case(alu_pkg::add_registers, 8'h0f, 8'h01, 8'h00, 8'h00, 16'h0010, 8'h20, 0);
    op_case(alu_pkg::add_registers, 8'h7f, 8'h01, 8'h00, 8'h00, 16'h0080, 8'h2c, 0);
    op_case(alu_pkg::add_with_carry,
      8'hff, 8'h00, 8'h00, 8'h01, 16'h0000, 8'h23, 0);
    op_case(alu_pkg::subtract_registers,
      8'h00, 8'h01, 8'h00, 8'h00, 16'h00ff, 8'h25, 0);
    op_case(alu_pkg::subtract_immediate,
      8'h80, 8'h00, 8'h01, 8'h00, 16'h007f, 8'h28, 0);
    op_case(alu_pkg::subtract_with_carry,
      8'h10, 8'h0f, 8'h00, 8'h01, 16'h0000, 8'h22, 0);
    op_case(alu_pkg::subtract_immediate_with_carry,
      8'h05, 8'h00, 8'h05, 8'h01, 16'h00ff, 8'h25, 0);
    op_case(alu_pkg::add_immediate_word,
      8'hff, 8'h7f, 8'h01, 8'h00, 16'h8000, 8'h0c, 1);
    op_case(alu_pkg::add_immediate_word,
      8'hff, 8'hff, 8'h01, 8'h00, 16'h0000, 8'h03, 1);
    op_case(alu_pkg::subtract_immediate_word,
      8'h00, 8'h00, 8'h01, 8'h20, 16'hffff, 8'h35, 1);
    op_case(alu_pkg::and_registers, 8'hf0, 8'h0f, 8'h00, 8'h09, 16'h0000, 8'h03, 0);
    op_case(alu_pkg::and_immediate, 8'haa, 8'h00, 8'hf0, 8'h00, 16'h00a0, 8'h04, 0);
    op_case(alu_pkg::or_registers, 8'h80, 8'h01, 8'h00, 8'h00, 16'h0081, 8'h04, 0);
    op_case(alu_pkg::or_immediate, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0000, 8'h02, 0);
    op_case(alu_pkg::exclusive_or_registers,
      8'h5a, 8'h5a, 8'h00, 8'h21, 16'h0000, 8'h23, 0);
    op_case(alu_pkg::set_mask_bits,
      8'h01, 8'h00, 8'h80, 8'h00, 16'h0081, 8'h04, 0);
    op_case(alu_pkg::clear_mask_bits,
      8'hff, 8'h00, 8'h0f, 8'h00, 16'h00f0, 8'h04, 0);
    op_case(alu_pkg::test_zero_minus,
      8'h80, 8'h00, 8'h00, 8'h08, 16'h0080, 8'h04, 0);
    op_case(alu_pkg::clear_register,
      8'h37, 8'h00, 8'h00, 8'h0c, 16'h0000, 8'h02, 0);
    op_case(alu_pkg::set_register_all_ones,
      8'h00, 8'h00, 8'h00, 8'h2f, 16'h00ff, 8'h2f, 0);
    op_case(alu_pkg::ones_complement,
      8'h00, 8'h00, 8'h00, 8'h00, 16'h00ff, 8'h05, 0);
    op_case(alu_pkg::twos_complement,
      8'h80, 8'h00, 8'h00, 8'h00, 16'h0080, 8'h0d, 0);
    op_case(alu_pkg::increment_register,
      8'h7f, 8'h00, 8'h00, 8'h00, 16'h0080, 8'h0c, 0);
    op_case(alu_pkg::decrement_register,
      8'h80, 8'h00, 8'h00, 8'h01, 16'h007f, 8'h09, 0);
    op_case(alu_pkg::multiply_unsigned,
      8'hff, 8'hff, 8'h00, 8'h00, 16'hfe01, 8'h01, 2);
    op_case(alu_pkg::multiply_unsigned,
      8'h00, 8'h55, 8'h00, 8'h01, 16'h0000, 8'h02, 2);
    op_case(alu_pkg::multiply_signed,
      8'hff, 8'h02, 8'h00, 8'h00, 16'hfffe, 8'h01, 2);
    op_case(alu_pkg::multiply_signed_unsigned,
      8'hff, 8'hff, 8'h00, 8'h00, 16'hff01, 8'h01, 2);
    op_case(alu_pkg::fractional_multiply_unsigned,
      8'h80, 8'h80, 8'h00, 8'h01, 16'h8000, 8'h00, 2);
    op_case(alu_pkg::fractional_multiply_signed,
      8'hc0, 8'h40, 8'h00, 8'h00, 16'he000, 8'h01, 2);
    op_case(alu_pkg::fractional_multiply_mixed,
      8'h80, 8'h02, 8'h00, 8'h00, 16'hfe00, 8'h01, 2);
    ce_case();
    finish_test();
  end

  // The sequence needs well under a thousand cycles; a hang is cut off far beyond that
  initial
  begin
    #100000;
    fail_count++;
    finish_test();
  end
endmodule // tb
